// ### inc/boe_defs.svh
`ifndef BOE_DEFS_SVH
`define BOE_DEFS_SVH
// Overview of operation
// [RULE1] An absolute jump loads its 11-bit immediate into program counter bits 10 to 0.
// [RULE2] An absolute jump fills program counter bits 14 to 11 from latch bits 6 to 3.
// [RULE3] An absolute jump takes two instruction cycles and changes no flag.
// [RULE4] OR-with-literal ORs the accumulator with an 8-bit literal into the accumulator and updates zero.
// [RULE5] Increment adds one to the addressed file register (0 to 127) and updates zero.
// [RULE6] For increment, OR-with-file and the shifts, destination 0 selects the accumulator and 1 the file register.
// [RULE7] OR-with-file ORs the accumulator with the file register into the selected destination and updates zero.
// [RULE8] Left shift moves bit 7 to carry, bits 6 to 0 up one place and a zero into bit 0, updating carry and zero.
// [RULE9] Right shift puts a zero in bit 7, moves bits 7 to 1 down one place and bit 0 to carry, updating carry and zero.
// [RULE10] Where zero is updated it is set for an all-zero 8-bit result and cleared otherwise.
// [RULE11] Every other operation completes in one instruction cycle and simply advances the program counter.

// Register port offsets (bit 7 set selects the file register space)
`define BOE_ACC_OFS      8'h00
`define BOE_LATCH_OFS    8'h01
`define BOE_STATUS_OFS   8'h02
`define BOE_PC_LO_OFS    8'h03
`define BOE_PC_HI_OFS    8'h04
`define BOE_FILE_SEL_BIT 7

// Status field positions
`define BOE_ST_CARRY_BIT 0
`define BOE_ST_ZERO_BIT  1

// Jump field positions
`define BOE_LATCH_JMP_HI 6
`define BOE_LATCH_JMP_LO 3

// Reset values
`define BOE_ACC_RST      8'h00
`define BOE_LATCH_RST    7'h00
`define BOE_PC_RST       15'h0000
`endif

// ### inc/boe_pkg.sv
package boe_pkg;
  // Operation codes from the decoder
  typedef enum logic [2:0] {
    OP_ABSOLUTE_JUMP       = 3'h0,
    OP_OR_LITERAL_INTO_ACC = 3'h1,
    OP_INCREMENT_FILE      = 3'h2,
    OP_OR_ACC_WITH_FILE    = 3'h3,
    OP_LOGICAL_SHIFT_LEFT  = 3'h4,
    OP_LOGICAL_SHIFT_RIGHT = 3'h5
  } boe_op_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_JMP2 = 2'h2
  } boe_state_t;

  // Whole state of the execution core
  typedef struct packed {
    boe_state_t st;
    boe_op_t    op;
    logic [6:0] f;
    logic       d;
    logic [10:0] k;
    logic [7:0] acc;
    logic [6:0] latch;
    logic       carry;
    logic       zero;
    logic [14:0] pc;
    logic       done;
    logic       rsel;
    logic [7:0] rdata;
  } boe_core_t;
endpackage : boe_pkg

// ### inc/boe_file_if.sv
interface boe_file_if;
  logic       we;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr_a;
  logic [7:0] rdata_a;
  logic [6:0] raddr_b;
  logic [7:0] rdata_b;

  modport core (output we, waddr, wdata, raddr_a, raddr_b,
                input  rdata_a, rdata_b);
  modport mem  (input  we, waddr, wdata, raddr_a, raddr_b,
                output rdata_a, rdata_b);
endinterface : boe_file_if

// ### src/boe_file_mem.sv
module boe_file_mem #(
  parameter int DEPTH = 128
) (
  // Clock
  input  wire logic mclk_i,
  // File port
  boe_file_if.mem   fp
);
  initial begin
    if (DEPTH != 128) begin
      $error("boe_file_mem: DEPTH must be 128");
    end
  end

  logic [7:0] mem_q [DEPTH];
  logic [7:0] ra_q;
  logic [7:0] rb_q;

  // One write port, two registered read ports
  always_ff @(posedge mclk_i) begin
    if (fp.we) begin
      mem_q[fp.waddr] <= fp.wdata;
    end
    ra_q <= mem_q[fp.raddr_a];
    rb_q <= mem_q[fp.raddr_b];
  end

  assign fp.rdata_a = ra_q;
  assign fp.rdata_b = rb_q;
endmodule : boe_file_mem

// ### src/boe_exec.sv
`include "boe_defs.svh"

module boe_exec #(
  parameter int FILE_DEPTH = 128
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Instruction issue from the decoder
  input  wire logic        instr_valid_i,
  input  wire logic [2:0]  instr_op_i,
  input  wire logic [10:0] instr_k_i,
  input  wire logic [6:0]  instr_f_i,
  input  wire logic        instr_d_i,
  output logic             instr_ready_o,
  output logic             instr_done_o,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  // Architectural state
  output logic [14:0]      pc_o,
  output logic [7:0]       acc_o,
  output logic             carry_o,
  output logic             zero_o
);
  initial begin
    if (FILE_DEPTH != 128) begin
      $error("boe_exec: FILE_DEPTH must be 128");
    end
  end

  boe_file_if fif ();

  boe_pkg::boe_core_t s_q;
  boe_pkg::boe_core_t s_d;

  logic [7:0] src;
  logic [7:0] res;
  logic       to_file;
  logic       exec_we;
  logic       host_file;

  // File register storage
  boe_file_mem #(
    .DEPTH (FILE_DEPTH)
  ) u_mem (
    .mclk_i (mclk_i),
    .fp     (fif.mem)
  );

  assign src       = fif.rdata_a;
  assign host_file = reg_addr_i[`BOE_FILE_SEL_BIT];

  // Result and write-back computation in the execute cycle
  always_comb begin
    res     = 8'h00;
    to_file = 1'b0;
    unique case (s_q.op)
      boe_pkg::OP_OR_LITERAL_INTO_ACC: begin
        res = s_q.acc | s_q.k[7:0]; // see [RULE4]
      end
      boe_pkg::OP_INCREMENT_FILE: begin
        res     = src + 8'h01; // see [RULE5]
        to_file = s_q.d; // see [RULE6]
      end
      boe_pkg::OP_OR_ACC_WITH_FILE: begin
        res     = s_q.acc | src; // see [RULE7]
        to_file = s_q.d; // see [RULE6]
      end
      boe_pkg::OP_LOGICAL_SHIFT_LEFT: begin
        res     = {src[6:0], 1'b0}; // see [RULE8]
        to_file = s_q.d; // see [RULE6]
      end
      boe_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
        res     = {1'b0, src[7:1]}; // see [RULE9]
        to_file = s_q.d; // see [RULE6]
      end
      default: begin
        res     = 8'h00;
        to_file = 1'b0;
      end
    endcase
  end

  assign exec_we = (s_q.st == boe_pkg::ST_EXEC) && to_file;

  // File port: execute write takes the port over a host write
  always_comb begin
    fif.we      = exec_we | (reg_wr_i & host_file);
    fif.waddr   = exec_we ? s_q.f : reg_addr_i[6:0];
    fif.wdata   = exec_we ? res : reg_wdata_i;
    fif.raddr_a = (s_q.st == boe_pkg::ST_IDLE) ? instr_f_i : s_q.f;
    fif.raddr_b = reg_addr_i[6:0];
  end

  // Sequencer, flags and register port
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      boe_pkg::ST_IDLE: begin
        if (instr_valid_i) begin
          s_d.op = boe_pkg::boe_op_t'(instr_op_i);
          s_d.f  = instr_f_i;
          s_d.d  = instr_d_i;
          s_d.k  = instr_k_i;
          s_d.st = boe_pkg::ST_EXEC;
        end
      end
      boe_pkg::ST_EXEC: begin
        if (s_q.op == boe_pkg::OP_ABSOLUTE_JUMP) begin
          s_d.pc = {s_q.latch[`BOE_LATCH_JMP_HI:`BOE_LATCH_JMP_LO],
                    s_q.k}; // see [RULE1] see [RULE2]
          s_d.st = boe_pkg::ST_JMP2; // see [RULE3]
        end else begin
          if (s_q.op inside {boe_pkg::OP_OR_LITERAL_INTO_ACC,
                             boe_pkg::OP_INCREMENT_FILE,
                             boe_pkg::OP_OR_ACC_WITH_FILE,
                             boe_pkg::OP_LOGICAL_SHIFT_LEFT,
                             boe_pkg::OP_LOGICAL_SHIFT_RIGHT}) begin
            s_d.zero = (res == 8'h00); // see [RULE10]
            if (!to_file) begin
              s_d.acc = res; // see [RULE6]
            end
          end
          if (s_q.op == boe_pkg::OP_LOGICAL_SHIFT_LEFT) begin
            s_d.carry = src[7]; // see [RULE8]
          end
          if (s_q.op == boe_pkg::OP_LOGICAL_SHIFT_RIGHT) begin
            s_d.carry = src[0]; // see [RULE9]
          end
          s_d.pc   = s_q.pc + 15'h0001; // see [RULE11]
          s_d.done = 1'b1;
          s_d.st   = boe_pkg::ST_IDLE;
        end
      end
      boe_pkg::ST_JMP2: begin
        s_d.done = 1'b1; // see [RULE3]
        s_d.st   = boe_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = boe_pkg::ST_IDLE;
      end
    endcase

    // Host writes land after the execute update and win over it
    if (reg_wr_i && !host_file) begin
      unique case (reg_addr_i)
        `BOE_ACC_OFS:    s_d.acc   = reg_wdata_i;
        `BOE_LATCH_OFS:  s_d.latch = reg_wdata_i[6:0];
        `BOE_STATUS_OFS: begin
          s_d.carry = reg_wdata_i[`BOE_ST_CARRY_BIT];
          s_d.zero  = reg_wdata_i[`BOE_ST_ZERO_BIT];
        end
        `BOE_PC_LO_OFS:  s_d.pc[7:0]  = reg_wdata_i;
        `BOE_PC_HI_OFS:  s_d.pc[14:8] = reg_wdata_i[6:0];
        default: begin
        end
      endcase
    end

    // Read data are captured for the following cycle
    s_d.rsel  = reg_rd_i & host_file;
    s_d.rdata = 8'h00;
    if (reg_rd_i && !host_file) begin
      unique case (reg_addr_i)
        `BOE_ACC_OFS:    s_d.rdata = s_q.acc;
        `BOE_LATCH_OFS:  s_d.rdata = {1'b0, s_q.latch};
        `BOE_STATUS_OFS: s_d.rdata = {6'h00, s_q.zero, s_q.carry};
        `BOE_PC_LO_OFS:  s_d.rdata = s_q.pc[7:0];
        `BOE_PC_HI_OFS:  s_d.rdata = {1'b0, s_q.pc[14:8]};
        default:         s_d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q       <= '0;
      s_q.st    <= boe_pkg::ST_IDLE;
      s_q.acc   <= `BOE_ACC_RST;
      s_q.latch <= `BOE_LATCH_RST;
      s_q.pc    <= `BOE_PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign instr_ready_o = (s_q.st == boe_pkg::ST_IDLE);
  assign instr_done_o  = s_q.done;
  assign reg_rdata_o   = s_q.rsel ? fif.rdata_b : s_q.rdata;
  assign pc_o          = s_q.pc;
  assign acc_o         = s_q.acc;
  assign carry_o       = s_q.carry;
  assign zero_o        = s_q.zero;
endmodule : boe_exec

// ### dv/boe_exec_props.sv
module boe_exec_props (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Instruction issue
  input wire logic        instr_valid_i,
  input wire logic [2:0]  instr_op_i,
  input wire logic [10:0] instr_k_i,
  input wire logic        instr_d_i,
  input wire logic        instr_ready_o,
  input wire logic        instr_done_o,
  // Architectural state
  input wire logic [14:0] pc_o,
  input wire logic [7:0]  acc_o,
  input wire logic        carry_o,
  input wire logic        zero_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic jp;
  logic ol;
  logic fw;
  // Accept and operation decode
  assign tk = instr_valid_i & instr_ready_o;
  assign jp = tk & (instr_op_i == boe_pkg::OP_ABSOLUTE_JUMP);
  assign ol = tk & (instr_op_i == boe_pkg::OP_OR_LITERAL_INTO_ACC);
  assign fw = tk & (instr_op_i >= 3'h2) & (instr_op_i <= 3'h5);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_op_latency: assert property (
    tk && !jp |=> !instr_ready_o ##1 instr_done_o) else $error("op late");
  a_pc_advance: assert property (
    tk && !jp |-> ##2 pc_o == $past(pc_o, 2) + 15'h0001)
    else $error("pc not advanced");
  a_jump_latency: assert property (
    jp |=> !instr_ready_o [*2] ##1 instr_done_o) else $error("jump late");
  a_jump_target: assert property (
    jp |-> ##2 pc_o[10:0] == $past(instr_k_i, 2)) else $error("bad target");
  a_jump_flags: assert property (
    jp |=> ($stable(carry_o) && $stable(zero_o)) [*3])
    else $error("jump changed flags");
  a_orl_result: assert property (
    ol |-> ##2 acc_o == ($past(acc_o, 2) | 8'($past(instr_k_i, 2))))
    else $error("bad or literal");
  a_orl_zero: assert property (
    ol |-> ##2 zero_o == (acc_o == 8'h00)) else $error("bad zero");
  a_file_keeps_acc: assert property (
    fw && instr_d_i |-> ##2 acc_o == $past(acc_o, 2))
    else $error("acc hit by file op");
endmodule : boe_exec_props

bind boe_exec boe_exec_props chk_u (
  .mclk_i, .rst_n_i, .instr_valid_i, .instr_op_i, .instr_k_i,
  .instr_d_i, .instr_ready_o, .instr_done_o, .pc_o, .acc_o,
  .carry_o, .zero_o
);

// ### dv/boe_dec_model.sv
module boe_dec_model (
  // Clock and handshake
  input  wire logic   mclk_i,
  input  wire logic   ready_i,
  // Instruction fields
  output logic        valid_o,
  output logic [2:0]  op_o,
  output logic [10:0] k_o,
  output logic [6:0]  f_o,
  output logic        d_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle decoder at time zero
  initial begin
    valid_o = 1'b0;
    op_o = 3'h7;
    k_o = 11'h000;
    f_o = 7'h00;
    d_o = 1'b0;
  end

  // Hold one instruction until accepted, then scramble the fields
  task automatic issue(input logic [2:0] op, input logic [10:0] k,
                       input logic [6:0] f, input logic d);
    logic rdy;
    valid_o <= 1'b1;
    op_o <= op;
    k_o <= k;
    f_o <= f;
    d_o <= d;
    rdy = 1'b0;
    while (!rdy) begin
      @(negedge mclk_i);
      rdy = (ready_i === 1'b1);
      @(posedge mclk_i);
    end
    valid_o <= 1'b0;
    op_o <= ~op;
    k_o <= ~k;
    f_o <= ~f;
    d_o <= ~d;
  endtask : issue
endmodule : boe_dec_model

// ### dv/tb_branch_or_inc_shift_exec.sv
module tb_branch_or_inc_shift_exec;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        instr_valid_i, instr_d_i, instr_ready_o, instr_done_o;
  logic [2:0]  instr_op_i;
  logic [10:0] instr_k_i;
  logic [6:0]  instr_f_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, acc_o;
  logic        reg_wr_i, reg_rd_i, carry_o, zero_o;
  logic [14:0] pc_o;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  // Clock and hang guard
  always #2.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      results();
    end
  end

  boe_exec dut_u (.mclk_i, .rst_n_i, .instr_valid_i, .instr_op_i,
    .instr_k_i, .instr_f_i, .instr_d_i, .instr_ready_o, .instr_done_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .pc_o, .acc_o, .carry_o, .zero_o);
  boe_dec_model dec_u (.mclk_i, .ready_i(instr_ready_o),
    .valid_o(instr_valid_i), .op_o(instr_op_i), .k_o(instr_k_i),
    .f_o(instr_f_i), .d_o(instr_d_i));

  task automatic chk(input logic [14:0] got, input logic [14:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    @(posedge mclk_i); // Gap so the next strobe is set in a later step
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    @(negedge mclk_i);
    v = reg_rdata_o;
    @(posedge mclk_i);
  endtask : rd

  // Issue one instruction and wait a bounded time for completion
  task automatic run(input logic [2:0] o, input logic [10:0] k,
                     input logic [6:0] f, input logic d);
    int n;
    dec_u.issue(o, k, f, d);
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (instr_done_o !== 1'b1 && n < 6);
    chk({14'h0000, instr_done_o}, 15'h0001);
    @(posedge mclk_i);
  endtask : run

  // Preset a file register, run, compare {carry, result} and zero
  task automatic do_op(input logic [2:0] o, input logic [10:0] k,
    input logic [6:0] f, input logic d, input logic [7:0] fv,
    input logic [8:0] exp);
    logic [7:0] v;
    wr({1'b1, f}, fv);
    run(o, k, f, d);
    if (d) rd({1'b1, f}, v);
    else v = acc_o;
    chk({6'h00, carry_o, v}, {6'h00, exp});
    chk({14'h0000, zero_o}, {14'h0000, exp[7:0] == 8'h00});
  endtask : do_op

  task automatic t_jump;
    logic [7:0] v;
    wr(8'h01, 8'h68);
    wr(8'h02, 8'h03);
    run(3'h0, 11'h7FF, 7'h00, 1'b0);
    chk(pc_o, 15'h6FFF);
    chk({13'h0000, carry_o, zero_o}, 15'h0003);
    rd(8'h03, v);
    chk({7'h00, v}, 15'h00FF);
    rd(8'h04, v);
    chk({7'h00, v}, 15'h006F);
    rd(8'h01, v);
    chk({7'h00, v}, 15'h0068);
  endtask : t_jump

  task automatic t_logic;
    wr(8'h00, 8'h00);
    do_op(3'h1, 11'h000, 7'h00, 1'b0, 8'h00, 9'h100);
    do_op(3'h1, 11'h0A5, 7'h00, 1'b0, 8'h00, 9'h1A5);
    do_op(3'h3, 11'h000, 7'h10, 1'b1, 8'h50, 9'h1F5);
    do_op(3'h3, 11'h000, 7'h11, 1'b0, 8'h00, 9'h1A5);
  endtask : t_logic

  task automatic t_arith;
    do_op(3'h2, 11'h000, 7'h7F, 1'b1, 8'hFF, 9'h100);
    do_op(3'h2, 11'h000, 7'h7F, 1'b0, 8'h41, 9'h142);
    do_op(3'h4, 11'h000, 7'h20, 1'b0, 8'h81, 9'h102);
    do_op(3'h4, 11'h000, 7'h21, 1'b1, 8'h80, 9'h100);
    do_op(3'h4, 11'h000, 7'h22, 1'b0, 8'h7F, 9'h0FE);
    do_op(3'h5, 11'h000, 7'h23, 1'b1, 8'h81, 9'h140);
    do_op(3'h5, 11'h000, 7'h24, 1'b0, 8'hFE, 9'h07F);
    do_op(3'h5, 11'h000, 7'h25, 1'b1, 8'h01, 9'h100);
  endtask : t_arith

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  // Main sequence
  initial begin
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    chk(pc_o, 15'h0000);
    t_jump();
    t_logic();
    t_arith();
    results();
  end
endmodule : tb_branch_or_inc_shift_exec
